// *** verilog/eight_bit_timer.sv ***
// 8-bit timer with capture, compare, one-pulse mode and APB registers
// ==========================================================
// What this block does
// - counter wrap from FFh to 00h sets overflow flag in every mode
// - overflow interrupt only with enable set and cpu mask clear; else pending
// - shadow counter access never clears overflow flag
// - counter access after a status access clears overflow flag
// - both counter registers read the count; writing either resets it to FCh
// - wait mode leaves the timer running unchanged
// - halt stops counting; resume from held count, or reset count after reset
// - one-pulse select in control two enables one-pulse mode
// - capture one edge select picks the active edge in one-pulse mode
// - compare one output enable hands the pin to compare one
// - valid capture one edge: count FCh, during level, flag, capture FDh
// - counter equal compare one: after-pulse level driven on the pin
// - pin follows level bits; equal levels give a steady pin
// - capture flag raises interrupt when capture interrupt enable is set
// - status read with flag set then capture register access clears flag
// - pulse lasts compare value plus five ticks; divide 2, 4, 8, 8000
// - one-pulse mode never sets compare one flag; compare two still works
// - pwm and one-pulse both set: pwm only
// - one-pulse: capture one loads FDh into its capture register, not the count; capture two normal
// - one-pulse: compare two flags time but drives no pin
// - capture registers hold captured count; compare registers reset to 00h
//
// Local design decisions: the address map and the APB interface to the registers.
`include "timer_consts.svh"
`default_nettype none
module eight_bit_timer #(
    parameter logic [15:0] SLOW_DIV = `PRESCALE_FACTOR_DIV_SLOW
) (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // cpu state
    input wire logic haltMode,
    input wire logic waitMode,
    input wire logic irqMask,
    // pins
    input wire logic captureOnePin,
    input wire logic captureTwoPin,
    output logic compareOnePin,
    output logic compareOneDrive,
    output logic compareTwoPin,
    output logic compareTwoDrive,
    // interrupt request
    output logic timerIrq
);
    timer_pkg::ctrl_one_t ctrl1_ff, nxt_ctrl1;
    timer_pkg::ctrl_two_t ctrl2_ff, nxt_ctrl2;
    timer_pkg::status_t stat_ff, nxt_stat, armed_ff, nxt_armed;
    timer_pkg::pulse_state_t pulse_ff, nxt_pulse;
    logic [7:0] count_ff, nxt_count, cap1_ff, nxt_cap1, cap2_ff, nxt_cap2;
    logic [7:0] cmp1_ff, nxt_cmp1, cmp2_ff, nxt_cmp2;
    logic [31:0] rdata_ff, nxt_rdata;
    logic pin1_ff, nxt_pin1, pin2_ff, nxt_pin2, irq_ff, nxt_irq;
    logic tick, edge1, edge2, restart;
    logic setupPh, accessPh, wrEn, rdEn;
    logic onePulse, pwmOn, wrap, reload;
    logic statusAcc, cap1Acc, cap2Acc, cmp1Acc, cmp2Acc, countAcc, shadowAcc;

    // ==========================================================
    // address decode
    function automatic logic addrHit(input logic [7:0] a);
        addrHit = (a == `OFS_CTRL_ONE) || (a == `OFS_CTRL_TWO) ||
            (a == `OFS_STATUS) || (a == `OFS_STATUS_ALT) ||
            (a == `OFS_CAP_ONE) || (a == `OFS_CMP_ONE) ||
            (a == `OFS_CMP_TWO) || (a == `OFS_COUNT) ||
            (a == `OFS_COUNT_SHADOW) || (a == `OFS_CAP_TWO);
    endfunction : addrHit

    function automatic logic [7:0] readReg(input logic [7:0] a);
        if (a == `OFS_CTRL_ONE) begin
            readReg = ctrl1_ff;
        end else if (a == `OFS_CTRL_TWO) begin
            readReg = ctrl2_ff;
        end else if (a == `OFS_STATUS || a == `OFS_STATUS_ALT) begin
            readReg = {stat_ff[7:3], 3'h0};
        end else if (a == `OFS_CAP_ONE) begin
            readReg = cap1_ff;
        end else if (a == `OFS_CMP_ONE) begin
            readReg = cmp1_ff;
        end else if (a == `OFS_CMP_TWO) begin
            readReg = cmp2_ff;
        end else if (a == `OFS_COUNT || a == `OFS_COUNT_SHADOW) begin
            readReg = count_ff;
        end else if (a == `OFS_CAP_TWO) begin
            readReg = cap2_ff;
        end else begin
            readReg = `REG_ZERO;
        end
    endfunction : readReg

    // ==========================================================
    // apb handshake: zero wait states
    assign setupPh = psel && !penable;
    assign accessPh = psel && penable;
    assign wrEn = accessPh && pwrite && addrHit(paddr);
    assign rdEn = accessPh && !pwrite && addrHit(paddr);
    assign pready = 1'b1;
    assign pslverr = accessPh && !addrHit(paddr);
    assign prdata = rdata_ff;

    always_comb begin
        statusAcc = 1'b0;
        cap1Acc = 1'b0;
        cap2Acc = 1'b0;
        cmp1Acc = 1'b0;
        cmp2Acc = 1'b0;
        countAcc = 1'b0;
        shadowAcc = 1'b0;
        if (!accessPh) begin
            statusAcc = 1'b0;
        end else if (paddr == `OFS_STATUS || paddr == `OFS_STATUS_ALT) begin
            statusAcc = rdEn;
        end else if (paddr == `OFS_CAP_ONE) begin
            cap1Acc = 1'b1;
        end else if (paddr == `OFS_CAP_TWO) begin
            cap2Acc = 1'b1;
        end else if (paddr == `OFS_CMP_ONE) begin
            cmp1Acc = 1'b1;
        end else if (paddr == `OFS_CMP_TWO) begin
            cmp2Acc = 1'b1;
        end else if (paddr == `OFS_COUNT) begin
            countAcc = 1'b1;
        end else if (paddr == `OFS_COUNT_SHADOW) begin
            shadowAcc = 1'b1;
        end
    end

    // ==========================================================
    // clocking and pins
    assign onePulse = ctrl2_ff.onePulseSelect && !ctrl2_ff.pwmSelect;
    assign pwmOn = ctrl2_ff.pwmSelect;
    assign reload = pwrite && (countAcc || shadowAcc);
    assign restart = reload || (onePulse && edge1);

    // halt gates ticks only; wait mode has no effect
    timer_prescaler #(
        .SLOW_DIV(SLOW_DIV)
    ) u_prescale_factor (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .run(!haltMode),
        .restart(restart),
        .sel(ctrl2_ff.prescaleSelect),
        .tick(tick)
    );

    pin_sync u_sync1 (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .pinIn(captureOnePin),
        .risingSel(ctrl1_ff.captureOneEdgeSelect),
        .edgePulse(edge1)
    );

    pin_sync u_sync2 (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .pinIn(captureTwoPin),
        .risingSel(ctrl1_ff.captureTwoEdgeSelect),
        .edgePulse(edge2)
    );

    // ==========================================================
    // counter, captures, flags, pins
    always_comb begin
        nxt_ctrl1 = ctrl1_ff;
        nxt_ctrl2 = ctrl2_ff;
        nxt_cmp1 = cmp1_ff;
        nxt_cmp2 = cmp2_ff;
        nxt_count = count_ff;
        nxt_cap1 = cap1_ff;
        nxt_cap2 = cap2_ff;
        nxt_pin1 = pin1_ff;
        nxt_pin2 = pin2_ff;
        nxt_pulse = pulse_ff;
        nxt_stat = stat_ff;
        nxt_armed = armed_ff;
        nxt_rdata = rdata_ff;
        wrap = 1'b0;
        if (setupPh) begin
            nxt_rdata = {24'h000000, readReg(paddr)};
        end
        if (wrEn && pstrb[0]) begin
            if (paddr == `OFS_CTRL_ONE) begin
                nxt_ctrl1 = pwdata[7:0];
            end else if (paddr == `OFS_CTRL_TWO) begin
                nxt_ctrl2 = pwdata[7:0];
            end else if (paddr == `OFS_CMP_ONE) begin
                nxt_cmp1 = pwdata[7:0];
            end else if (paddr == `OFS_CMP_TWO) begin
                nxt_cmp2 = pwdata[7:0];
            end
        end
        // counting; reloads below take priority
        if (tick) begin
            nxt_count = count_ff + 8'h01;
            wrap = (count_ff == `COUNT_MAX);
        end
        if (pwmOn && tick && count_ff == cmp2_ff) begin
            nxt_count = `COUNT_RESET;
            nxt_pin1 = ctrl1_ff.duringPulseLevel;
        end else if (pwmOn && tick && count_ff == cmp1_ff) begin
            nxt_pin1 = ctrl1_ff.afterPulseLevel;
        end
        // one-pulse start and end
        case (pulse_ff)
            timer_pkg::PULSE_ACTIVE: begin
                if (!onePulse) begin
                    nxt_pulse = timer_pkg::PULSE_IDLE;
                end else if (tick && count_ff == cmp1_ff) begin
                    nxt_pin1 = ctrl1_ff.afterPulseLevel;
                    nxt_pulse = timer_pkg::PULSE_DONE;
                end
            end
            timer_pkg::PULSE_DONE: begin
                if (!onePulse) begin
                    nxt_pulse = timer_pkg::PULSE_IDLE;
                end
            end
            default: begin
                nxt_pulse = timer_pkg::PULSE_IDLE;
            end
        endcase
        if (onePulse && edge1) begin
            nxt_count = `COUNT_RESET;
            nxt_pin1 = ctrl1_ff.duringPulseLevel;
            nxt_cap1 = 8'(`CAP_ONE_PULSE_LOAD);
            nxt_pulse = timer_pkg::PULSE_ACTIVE;
        end else if (edge1) begin
            nxt_cap1 = count_ff;
        end
        if (!onePulse && !pwmOn && tick && count_ff == cmp1_ff) begin
            nxt_pin1 = ctrl1_ff.afterPulseLevel;
        end
        // compare two drives no pin in one-pulse mode
        if (!onePulse && !pwmOn && tick && count_ff == cmp2_ff) begin
            nxt_pin2 = ctrl1_ff.duringPulseLevel;
        end
        if (edge2) begin
            nxt_cap2 = count_ff;
        end
        if (reload) begin
            nxt_count = `COUNT_RESET;
        end
        // flag clear sequence: status read arms, register access clears
        if (statusAcc) begin
            nxt_armed = armed_ff | stat_ff;
        end
        if (cap1Acc && armed_ff.captureOneFlag) begin
            nxt_stat.captureOneFlag = 1'b0;
            nxt_armed.captureOneFlag = 1'b0;
        end
        if (cap2Acc && armed_ff.captureTwoFlag) begin
            nxt_stat.captureTwoFlag = 1'b0;
            nxt_armed.captureTwoFlag = 1'b0;
        end
        if (cmp1Acc && armed_ff.compareOneFlag) begin
            nxt_stat.compareOneFlag = 1'b0;
            nxt_armed.compareOneFlag = 1'b0;
        end
        if (cmp2Acc && armed_ff.compareTwoFlag) begin
            nxt_stat.compareTwoFlag = 1'b0;
            nxt_armed.compareTwoFlag = 1'b0;
        end
        if (countAcc && armed_ff.overflowFlag) begin
            nxt_stat.overflowFlag = 1'b0;
            nxt_armed.overflowFlag = 1'b0;
        end
        // sets win over clears in the same cycle
        if (wrap) begin
            nxt_stat.overflowFlag = 1'b1;
        end
        if (edge1) begin
            nxt_stat.captureOneFlag = 1'b1;
        end
        if (edge2) begin
            nxt_stat.captureTwoFlag = 1'b1;
        end
        if (!onePulse && tick && count_ff == cmp1_ff) begin
            nxt_stat.compareOneFlag = 1'b1;
        end
        if (tick && count_ff == cmp2_ff) begin
            nxt_stat.compareTwoFlag = 1'b1;
        end
        nxt_stat.spare = 3'h0;
        nxt_irq = !irqMask && (
            (nxt_stat.overflowFlag && nxt_ctrl1.overflowIrqEnable) ||
            ((nxt_stat.captureOneFlag || nxt_stat.captureTwoFlag) &&
                nxt_ctrl1.captureIrqEnable) ||
            ((nxt_stat.compareOneFlag || nxt_stat.compareTwoFlag) &&
                nxt_ctrl1.compareIrqEnable));
    end

    // capture registers have no reset: value undefined until first capture
    always_ff @(posedge ref_clk) begin
        if (ce) begin
            cap1_ff <= nxt_cap1;
            cap2_ff <= nxt_cap2;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl1_ff <= '0;
            ctrl2_ff <= '0;
            stat_ff <= '0;
            armed_ff <= '0;
            pulse_ff <= timer_pkg::PULSE_IDLE;
            count_ff <= `COUNT_RESET;
            cmp1_ff <= `CMP_RESET;
            cmp2_ff <= `CMP_RESET;
            rdata_ff <= 32'h00000000;
            pin1_ff <= 1'b0;
            pin2_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else if (ce) begin
            ctrl1_ff <= nxt_ctrl1;
            ctrl2_ff <= nxt_ctrl2;
            stat_ff <= nxt_stat;
            armed_ff <= nxt_armed;
            pulse_ff <= nxt_pulse;
            count_ff <= nxt_count;
            cmp1_ff <= nxt_cmp1;
            cmp2_ff <= nxt_cmp2;
            rdata_ff <= nxt_rdata;
            pin1_ff <= nxt_pin1;
            pin2_ff <= nxt_pin2;
            irq_ff <= nxt_irq;
        end
    end

    assign compareOnePin = pin1_ff;
    assign compareOneDrive = ctrl2_ff.compareOneOutputEnable;
    assign compareTwoPin = pin2_ff;
    assign compareTwoDrive = ctrl2_ff.compareTwoOutputEnable && !onePulse;
    assign timerIrq = irq_ff;

    // ==========================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    ovf_flag_set_a: assert property (
        ce && tick && count_ff == `COUNT_MAX |=> stat_ff.overflowFlag)
        else $error("wrap did not set overflow flag");
    irq_mask_gate_a: assert property (
        ce && irqMask |=> !timerIrq)
        else $error("interrupt raised while masked");
    shadow_keeps_ovf_a: assert property (
        ce && stat_ff.overflowFlag && shadowAcc |=> stat_ff.overflowFlag)
        else $error("shadow access cleared overflow flag");
    count_clears_ovf_a: assert property (
        ce && countAcc && armed_ff.overflowFlag && !wrap |=> !stat_ff.overflowFlag)
        else $error("counter access did not clear overflow flag");
    write_resets_count_a: assert property (
        ce && reload |=> count_ff == `COUNT_RESET)
        else $error("counter write did not reload count");
    halt_holds_count_a: assert property (
        ce && haltMode && !restart && !(pwmOn && edge1) |=> $stable(count_ff))
        else $error("counter moved in halt");
    pulse_start_a: assert property (
        ce && onePulse && edge1 && !reload && !(wrEn && paddr == `OFS_CTRL_ONE)
        |=> count_ff == `COUNT_RESET && stat_ff.captureOneFlag &&
            compareOnePin == ctrl1_ff.duringPulseLevel &&
            cap1_ff == 8'(`CAP_ONE_PULSE_LOAD))
        else $error("one-pulse start incomplete");
    pulse_end_a: assert property (
        ce && pulse_ff == timer_pkg::PULSE_ACTIVE && onePulse && tick &&
            count_ff == cmp1_ff && !edge1 && !(wrEn && paddr == `OFS_CTRL_ONE)
        |=> compareOnePin == ctrl1_ff.afterPulseLevel)
        else $error("one-pulse end level missing");
    no_cmp1_flag_a: assert property (
        ce && onePulse && !stat_ff.compareOneFlag |=> !stat_ff.compareOneFlag)
        else $error("compare one flag set in one-pulse mode");
endmodule : eight_bit_timer
`default_nettype wire

// *** verilog/timer_consts.svh ***
// register offsets, reset values and dividers for the 8-bit timer
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH
// ==========================================================
// register byte offsets
`define OFS_CTRL_ONE 8'h00
`define OFS_CTRL_TWO 8'h04
`define OFS_STATUS 8'h08
`define OFS_STATUS_ALT 8'h0C
`define OFS_CAP_ONE 8'h10
`define OFS_CMP_ONE 8'h14
`define OFS_CMP_TWO 8'h18
`define OFS_COUNT 8'h1C
`define OFS_COUNT_SHADOW 8'h20
`define OFS_CAP_TWO 8'h24
// ==========================================================
// values
`define COUNT_RESET 8'hFC
`define COUNT_MAX 8'hFF
`define CMP_RESET 8'h00
`define CAP_ONE_PULSE_LOAD 16'hFFFD
`define REG_ZERO 8'h00
// ==========================================================
// prescale_select codes and divide factors
`define PRESCALE_FACTOR_SEL_2 2'h0
`define PRESCALE_FACTOR_SEL_4 2'h1
`define PRESCALE_FACTOR_SEL_8 2'h2
`define PRESCALE_FACTOR_DIV_2 16'h0002
`define PRESCALE_FACTOR_DIV_4 16'h0004
`define PRESCALE_FACTOR_DIV_8 16'h0008
`define PRESCALE_FACTOR_DIV_SLOW 16'h1F40
`endif

// *** verilog/timer_pkg.sv ***
// types shared by the 8-bit timer files
`default_nettype none
package timer_pkg;
    typedef struct packed {
        logic captureIrqEnable;
        logic compareIrqEnable;
        logic overflowIrqEnable;
        logic captureTwoEdgeSelect;
        logic duringPulseLevel;
        logic captureOneEdgeSelect;
        logic afterPulseLevel;
        logic spare;
    } ctrl_one_t;

    typedef struct packed {
        logic compareOneOutputEnable;
        logic compareTwoOutputEnable;
        logic onePulseSelect;
        logic pwmSelect;
        logic [1:0] prescaleSelect;
        logic [1:0] spare;
    } ctrl_two_t;

    typedef struct packed {
        logic captureOneFlag;
        logic compareOneFlag;
        logic overflowFlag;
        logic captureTwoFlag;
        logic compareTwoFlag;
        logic [2:0] spare;
    } status_t;

    typedef enum logic [2:0] {
        PULSE_IDLE = 3'b001,
        PULSE_ACTIVE = 3'b010,
        PULSE_DONE = 3'b100
    } pulse_state_t;
endpackage : timer_pkg
`default_nettype wire

// *** verilog/pin_sync.sv ***
// two-flop synchroniser with selectable active edge
`default_nettype none
module pin_sync (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic ce,
    // pin and edge choice
    input wire logic pinIn,
    input wire logic risingSel,
    // one-cycle active edge
    output logic edgePulse
);
    logic meta_ff, sync_ff, last_ff;
    logic nxt_meta, nxt_sync, nxt_last;

    always_comb begin
        nxt_meta = pinIn;
        nxt_sync = meta_ff;
        nxt_last = sync_ff;
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            last_ff <= 1'b0;
        end else if (ce) begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
            last_ff <= nxt_last;
        end
    end

    // edge seen only past the second stage
    assign edgePulse = risingSel ? (sync_ff & ~last_ff) : (~sync_ff & last_ff);
endmodule : pin_sync
`default_nettype wire

// *** verilog/timer_prescaler.sv ***
// divides the cpu clock into one-cycle timer ticks
`include "timer_consts.svh"
`default_nettype none
module timer_prescaler #(
    parameter logic [15:0] SLOW_DIV = `PRESCALE_FACTOR_DIV_SLOW
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic ce,
    // control
    input wire logic run,
    input wire logic restart,
    input wire logic [1:0] sel,
    // tick
    output logic tick
);
    logic [15:0] div_ff, nxt_div, limit;

    always_comb begin
        if (sel == `PRESCALE_FACTOR_SEL_2) begin
            limit = `PRESCALE_FACTOR_DIV_2;
        end else if (sel == `PRESCALE_FACTOR_SEL_4) begin
            limit = `PRESCALE_FACTOR_DIV_4;
        end else if (sel == `PRESCALE_FACTOR_SEL_8) begin
            limit = `PRESCALE_FACTOR_DIV_8;
        end else begin
            limit = SLOW_DIV;
        end
        nxt_div = div_ff;
        // restart aligns the first period with a counter reload
        if (restart || (run && div_ff >= limit - 16'h0001)) begin
            nxt_div = 16'h0000;
        end else if (run) begin
            nxt_div = div_ff + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_ff <= 16'h0000;
        end else if (ce) begin
            div_ff <= nxt_div;
        end
    end

    assign tick = run && !restart && (div_ff >= limit - 16'h0001);
endmodule : timer_prescaler
`default_nettype wire

// *** testbench/pin_partner.sv ***
// event source on the capture pins and a load that times the pulse
`default_nettype none
module pin_partner (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // bench request and load side
    input wire logic eventLevel,
    input wire logic compareOnePin,
    // pins toward the timer and measured pulse
    output logic captureOnePin,
    output logic captureTwoPin,
    output logic [15:0] highCycles
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========
    // source and load
    // pins change just after the edge, as a board-level source would
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            captureOnePin <= 1'b0;
            captureTwoPin <= 1'b0;
            highCycles <= 16'h0000;
        end else begin
            captureOnePin <= eventLevel;
            captureTwoPin <= eventLevel;
            if (eventLevel && !captureOnePin) begin
                highCycles <= 16'h0000;
            end else if (compareOnePin) begin
                highCycles <= highCycles + 16'h0001;
            end
        end
    end
endmodule : pin_partner
`default_nettype wire

// *** testbench/eight_bit_timer_tb.sv ***
// self-checking bench for the 8-bit timer
`include "timer_consts.svh"
`default_nettype none
module eight_bit_timer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
    logic haltMode, waitMode, irqMask, eventLevel, captureOnePin, captureTwoPin;
    logic compareOnePin, compareOneDrive, compareTwoPin, compareTwoDrive, timerIrq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, held;
    logic [15:0] highCycles;
    int err_total, total_checks;
    // ==========
    // parts
    // slow divider shortened so the /8000 path stays cheap to simulate
    eight_bit_timer #(.SLOW_DIV(16'h0010)) u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .haltMode(haltMode), .waitMode(waitMode), .irqMask(irqMask),
        .captureOnePin(captureOnePin), .captureTwoPin(captureTwoPin),
        .compareOnePin(compareOnePin), .compareOneDrive(compareOneDrive),
        .compareTwoPin(compareTwoPin), .compareTwoDrive(compareTwoDrive),
        .timerIrq(timerIrq));
    pin_partner u_partner (.ref_clk(ref_clk), .sys_rst(sys_rst), .eventLevel(eventLevel),
        .compareOnePin(compareOnePin), .captureOnePin(captureOnePin),
        .captureTwoPin(captureTwoPin), .highCycles(highCycles));
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // ==========
    // tasks
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // request held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= adr;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        if (pready !== 1'b1) begin
            err_total++;
            end_of_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdchk(input logic [7:0] adr, input logic [31:0] msk, input logic [31:0] exp,
        input string what);
        apb(1'b0, adr, 32'h00000000);
        chk(what, rd & msk, exp);
    endtask : rdchk
    // ==========
    // sequence
    initial begin
        repeat (100000) @(posedge ref_clk);
        err_total++;
        end_of_test();
    end
    initial begin
        {sys_rst, psel, penable, pwrite, haltMode, waitMode, irqMask} = 7'h4F;
        {paddr, pwdata, eventLevel, err_total, total_checks} = '0;
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rdchk(`OFS_COUNT, 32'hFF, 32'hFC, "count");
        rdchk(`OFS_COUNT_SHADOW, 32'hFF, 32'hFC, "shadow");
        rdchk(`OFS_CMP_ONE, 32'hFF, 32'h00, "cmp1");
        rdchk(`OFS_CMP_TWO, 32'hFF, 32'h00, "cmp2");
        apb(1'b1, `OFS_CMP_TWO, 32'h0000005A);
        rdchk(`OFS_CMP_TWO, 32'hFF, 32'h5A, "cmp2 rw");
        apb(1'b0, 8'h3C, 32'h00000000);
        chk("unmapped", {31'h0, err}, 32'h1);
        // count runs, then halt freezes it; a write reloads it
        haltMode <= 1'b0;
        repeat (20) @(posedge ref_clk);
        haltMode <= 1'b1;
        apb(1'b0, `OFS_COUNT, 32'h00000000);
        held = rd;
        repeat (10) @(posedge ref_clk);
        rdchk(`OFS_COUNT, 32'hFF, held, "halted");
        apb(1'b1, `OFS_COUNT, 32'h00000033);
        rdchk(`OFS_COUNT, 32'hFF, 32'hFC, "reload");
        // still halted: status read arms the stale compare one flag, compare write clears it
        apb(1'b0, `OFS_STATUS, 32'h00000000);
        // one-pulse: during level 1, after level 0, rising edges, /2
        apb(1'b1, `OFS_CMP_ONE, 32'h00000003);
        apb(1'b1, `OFS_CTRL_ONE, 32'h0000003C);
        apb(1'b1, `OFS_CTRL_TWO, 32'h000000E0);
        haltMode <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk("drive", {31'h0, compareOneDrive}, 32'h1);
        chk("cmp2 drive", {31'h0, compareTwoDrive}, 32'h0);
        eventLevel <= 1'b1;
        repeat (60) @(posedge ref_clk);
        chk("width", {16'h0000, highCycles}, 32'h00000010);
        chk("after", {31'h0, compareOnePin}, 32'h0);
        rdchk(`OFS_CAP_ONE, 32'hFF, 32'hFD, "cap1");
        rdchk(`OFS_STATUS, 32'hD0, 32'h90, "status");
        rdchk(`OFS_CAP_ONE, 32'hFF, 32'hFD, "cap1 again");
        rdchk(`OFS_STATUS, 32'h80, 32'h00, "cap1 clr");
        // clear the overflow left by the pulse so the wait below sees a fresh wrap
        apb(1'b0, `OFS_COUNT, 32'h00000000);
        rdchk(`OFS_STATUS, 32'h20, 32'h00, "ovf early clr");
        // overflow with wait mode held high throughout
        for (int i = 0; i < 700; i++) begin
            apb(1'b0, `OFS_STATUS, 32'h00000000);
            if (rd[5] === 1'b1) break;
        end
        chk("ovf", rd & 32'h20, 32'h20);
        chk("cmp2 flag", rd & 32'h08, 32'h08);
        chk("irq masked", {31'h0, timerIrq}, 32'h0);
        irqMask <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk("irq", {31'h0, timerIrq}, 32'h1);
        apb(1'b0, `OFS_COUNT_SHADOW, 32'h00000000);
        rdchk(`OFS_STATUS, 32'h20, 32'h20, "ovf kept");
        apb(1'b0, `OFS_COUNT, 32'h00000000);
        rdchk(`OFS_STATUS, 32'h20, 32'h00, "ovf clr");
        chk("cmp2 pin", {31'h0, compareTwoPin}, 32'h0);
        end_of_test();
    end
endmodule : eight_bit_timer_tb
`default_nettype wire
